// file: hdl/cad_alu16.sv
/*
  Sixteen-bit arithmetic unit: add, subtract, shifts and pass-through, with
  N Z V C flags. Purely combinational; the caller registers its results.
*/
`timescale 1ns/10ps
module cad_alu16
  import cad_pkg::*;
(
  input  wire cad_alu_op_t op_in,
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] b_in,
  input  wire logic        c_in,
  output logic      [15:0] res_out,
  output logic      [3:0]  flags_out
);

  logic [16:0] wide;
  logic        c_f;
  logic        v_f;

  always_comb begin
    wide    = 17'h00000;
    res_out = b_in;
    c_f     = c_in;
    v_f     = 1'b0;
    case (op_in)
      ALU_ADD: begin
        wide    = {1'b0, a_in} + {1'b0, b_in};
        res_out = wide[15:0];
        c_f     = wide[16];
        v_f     = (a_in[15] == b_in[15]) && (res_out[15] != a_in[15]);
      end
      ALU_SUB: begin
        wide    = {1'b0, a_in} - {1'b0, b_in};
        res_out = wide[15:0];
        c_f     = wide[16];
        v_f     = (a_in[15] != b_in[15]) && (res_out[15] != a_in[15]);
      end
      ALU_SHL: begin
        res_out = {a_in[14:0], 1'b0};
        c_f     = a_in[15];
        v_f     = res_out[15] ^ a_in[15];
      end
      ALU_SHR: begin
        res_out = {1'b0, a_in[15:1]};
        c_f     = a_in[0];
        v_f     = a_in[0];
      end
      default: begin
        res_out = b_in;
      end
    endcase
    flags_out = {res_out[15], (res_out == 16'h0000), v_f, c_f};
  end

endmodule

// file: hdl/cad_core.sv
/*
  Execution core for extended, indexed, implied and relative addressing and
  the 16-bit, multiply and index/stack operations. Memory on the same clock
  answers mem_rdata_in combinationally for mem_addr_out in the same cycle and
  writes mem_wdata_out at the edge that ends a cycle with mem_we_out high.
*/
// Function
// (RQ1) Extended mode: byte two is address high, byte three low; three bytes.
// (RQ2) Indexed mode: unsigned byte two plus index low, carry into high; two bytes.
// (RQ3) Indexed address lives in a temporary register; index stays untouched.
// (RQ4) Implied instructions take location from opcode; one byte long.
// (RQ5) Relative: signed offset added to PC low plus two, carry to high.
// (RQ6) Add B to index unsigned, carry into high byte, flags unchanged.
// (RQ7) Double add: memory word M:M+1 added into double accumulator.
// (RQ8) Double left shift: zero into bit 0, carry from old bit 15.
// (RQ9) Double right shift: zero into bit 15, carry from old bit 0.
// (RQ10) Double load fills A:B from memory and sets flags from data.
// (RQ11) Multiply A by B unsigned; 16-bit product in A:B, A high.
// (RQ12) Push index: low then high at SP, decrementing each; four cycles.
// (RQ13) Pull index: increment, read high; increment, read low; five cycles.
// (RQ14) Double store writes A at M, B at M+1; accumulators unchanged.
// (RQ15) Double subtract: memory word subtracted from double accumulator.
// (RQ16) Branch never: two-byte no-operation taking three cycles.
// (RQ17) Index compare sets N Z V C from index minus memory word.
// (RQ18) Double accumulator is A:B with A the upper byte.
// (RQ19) Index to SP loads X-1; SP to index loads SP+1; flags kept.
`timescale 1ns/10ps
module cad_core
  import cad_pkg::*;
#(
  parameter logic [15:0] RESET_PC = RST_PC,
  parameter logic [15:0] RESET_SP = RST_SP
) (
  input  wire logic        mclk_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  mem_rdata_in,
  output logic      [15:0] mem_addr_out,
  output logic      [7:0]  mem_wdata_out,
  output logic             mem_we_out,
  output logic             fetch_out,
  output logic             illegal_out,
  output logic      [15:0] pc_out,
  output logic      [15:0] sp_out,
  output logic      [15:0] index_out,
  output logic      [15:0] double_accumulator_out,
  output logic      [3:0]  cc_out
);

  typedef struct packed {
    cad_state_t  st;
    logic [7:0]  op;
    logic [3:0]  cyc;
    logic [3:0]  total;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] x;
    logic [15:0] ea;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  tmp;
    logic [3:0]  cc;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        illegal;
  } cad_core_state_t;

  localparam cad_core_state_t RST_VAL = '{
    st: ST_FETCH, op: 8'h00, cyc: 4'h0, total: CYC_NOP, pc: RESET_PC,
    sp: RESET_SP, x: 16'h0000, ea: 16'h0000, a: 8'h00, b: 8'h00,
    tmp: 8'h00, cc: RST_CC, addr: RESET_PC, wdata: 8'h00, we: 1'b0,
    illegal: 1'b0};

  cad_core_state_t s_q;
  cad_core_state_t s_d;
  logic [7:0]      op_cur;
  logic [15:0]     dacc;
  cad_alu_op_t     alu_op;
  logic [15:0]     alu_a;
  logic [15:0]     alu_res;
  logic [3:0]      alu_flags;
  logic [15:0]     product;
  logic [3:0]      cyc_done;
  logic            last;

  function automatic logic [3:0] cyc_of(input logic [7:0] op);
    case (op)
      OP_NOP:                                   cyc_of = CYC_NOP;
      OP_SHR_DOUBLE, OP_SHL_DOUBLE, OP_SP_TO_IDX,
      OP_IDX_TO_SP, OP_ADD_B_IDX:               cyc_of = CYC_SHORT;
      OP_PUSH_INDEX:                            cyc_of = CYC_PUSH_X;
      OP_PULL_INDEX:                            cyc_of = CYC_PULL_X;
      OP_MULTIPLY:                              cyc_of = CYC_MUL;
      OP_SUB_D_IMM, OP_CMP_X_IMM, OP_ADD_D_IMM:  cyc_of = CYC_ARITH_IMM;
      OP_SUB_D_IDX, OP_CMP_X_IDX, OP_ADD_D_IDX,
      OP_SUB_D_EXT, OP_CMP_X_EXT, OP_ADD_D_EXT:  cyc_of = CYC_ARITH_MEM;
      OP_LOAD_D_IMM:                            cyc_of = CYC_LOAD_IMM;
      OP_LOAD_D_IDX, OP_LOAD_D_EXT:             cyc_of = CYC_LOAD_MEM;
      OP_STORE_D_IDX, OP_STORE_D_EXT:           cyc_of = CYC_STORE_MEM;
      default: begin
        cyc_of = (op[7:4] == OP_BRANCH_HI) ? CYC_SHORT : 4'h0;
      end
    endcase
  endfunction

  function automatic cad_alu_op_t alu_of(input logic [7:0] op);
    case (op)
      OP_ADD_D_IMM, OP_ADD_D_IDX, OP_ADD_D_EXT: alu_of = ALU_ADD;
      OP_SUB_D_IMM, OP_SUB_D_IDX, OP_SUB_D_EXT,
      OP_CMP_X_IMM, OP_CMP_X_IDX, OP_CMP_X_EXT: alu_of = ALU_SUB;
      OP_SHL_DOUBLE:                            alu_of = ALU_SHL;
      OP_SHR_DOUBLE:                            alu_of = ALU_SHR;
      default:                                  alu_of = ALU_PASS;
    endcase
  endfunction

  // Carry out of the low byte ripples into the high byte
  function automatic logic [15:0] idx_addr(input logic [15:0] x, input logic [7:0] off);
    logic [8:0] lo;
    logic [7:0] hi;
    lo = {1'b0, x[7:0]} + {1'b0, off};
    hi = x[15:8] + {7'h00, lo[8]};
    return {hi, lo[7:0]};
  endfunction

  // A negative offset with no low-byte carry is a borrow from the high byte
  function automatic logic [15:0] rel_target(input logic [15:0] pc2, input logic [7:0] off);
    logic [8:0] lo;
    logic [7:0] hi;
    lo = {1'b0, pc2[7:0]} + {1'b0, off};
    if (off[7]) begin
      hi = lo[8] ? pc2[15:8] : pc2[15:8] - 8'h01;
    end else begin
      hi = pc2[15:8] + {7'h00, lo[8]};
    end
    return {hi, lo[7:0]};
  endfunction

  function automatic logic branch_taken(input logic [3:0] cond, input logic [3:0] cc);
    logic n;
    logic z;
    logic v;
    logic c;
    logic t;
    n = cc[CC_N];
    z = cc[CC_Z];
    v = cc[CC_V];
    c = cc[CC_C];
    case (cond[3:1])
      3'h0:    t = 1'b1;
      3'h1:    t = !(c | z);
      3'h2:    t = !c;
      3'h3:    t = !z;
      3'h4:    t = !v;
      3'h5:    t = !n;
      3'h6:    t = !(n ^ v);
      default: t = !(z | (n ^ v));
    endcase
    return cond[0] ? !t : t;
  endfunction

  assign dacc     = {s_q.a, s_q.b}; // RQ18
  assign op_cur   = (s_q.st == ST_FETCH) ? mem_rdata_in : s_q.op;
  assign alu_op   = alu_of(op_cur);
  assign alu_a    = (op_cur[3:0] == OP_CMP_X_IMM[3:0]) ? s_q.x : dacc;
  assign product  = {8'h00, s_q.a} * {8'h00, s_q.b};
  assign cyc_done = s_q.cyc + 4'h1;

  cad_alu16 u_alu (
    .op_in     (alu_op),
    .a_in      (alu_a),
    .b_in      ({s_q.tmp, mem_rdata_in}),
    .c_in      (s_q.cc[CC_C]),
    .res_out   (alu_res),
    .flags_out (alu_flags)
  );

  always_comb begin
    s_d     = s_q;
    s_d.we  = 1'b0;
    s_d.cyc = cyc_done;
    last    = cyc_done >= ((s_q.st == ST_FETCH) ? s_d.total : s_q.total);
    case (s_q.st)
      ST_FETCH: begin
        s_d.op      = mem_rdata_in;
        s_d.pc      = s_q.pc + 16'h0001;
        s_d.total   = (cyc_of(mem_rdata_in) == 4'h0) ? CYC_NOP : cyc_of(mem_rdata_in);
        s_d.illegal = (cyc_of(mem_rdata_in) == 4'h0);
        last        = cyc_done >= s_d.total;
        s_d.st      = last ? ST_FETCH : ST_PAD;
        case (mem_rdata_in)
          OP_ADD_B_IDX:  s_d.x = s_q.x + {8'h00, s_q.b}; // RQ6 RQ4
          OP_IDX_TO_SP:  s_d.sp = s_q.x - 16'h0001; // RQ19
          OP_SP_TO_IDX:  s_d.x = s_q.sp + 16'h0001; // RQ19
          OP_SHL_DOUBLE, OP_SHR_DOUBLE: begin
            {s_d.a, s_d.b} = alu_res; // RQ8 RQ9
            s_d.cc         = alu_flags;
          end
          OP_MULTIPLY: begin
            {s_d.a, s_d.b} = product; // RQ11
            s_d.cc[CC_C]   = product[7];
          end
          OP_PUSH_INDEX: begin
            s_d.addr  = s_q.sp; // RQ12
            s_d.wdata = s_q.x[7:0];
            s_d.we    = 1'b1;
            s_d.sp    = s_q.sp - 16'h0001;
            s_d.st    = ST_WR1;
          end
          OP_PULL_INDEX: begin
            s_d.sp   = s_q.sp + 16'h0001; // RQ13
            s_d.addr = s_q.sp + 16'h0001;
            s_d.st   = ST_RD_HI;
          end
          default: begin
            if (!s_d.illegal && mem_rdata_in != OP_NOP && mem_rdata_in[7:6] != 2'b00 ||
                mem_rdata_in[7:4] == OP_BRANCH_HI) begin
              s_d.st = ST_OP1;
            end
          end
        endcase
      end
      ST_OP1: begin
        s_d.pc = s_q.pc + 16'h0001;
        s_d.st = ST_OP2;
        if (s_q.op[7:4] == OP_BRANCH_HI) begin
          // Branch never and untaken branches fall through after byte two
          if (branch_taken(s_q.op[3:0], s_q.cc)) begin
            s_d.pc = rel_target(s_q.pc + 16'h0001, mem_rdata_in); // RQ5
          end
          s_d.st = last ? ST_FETCH : ST_PAD; // RQ16
        end else if (s_q.op[5:4] == MODE_IDX) begin
          s_d.ea   = idx_addr(s_q.x, mem_rdata_in); // RQ2 RQ3
          s_d.addr = idx_addr(s_q.x, mem_rdata_in);
          s_d.st   = ST_RD_HI;
          if (s_q.op == OP_STORE_D_IDX) begin
            s_d.wdata = s_q.a; // RQ14
            s_d.we    = 1'b1;
            s_d.st    = ST_WR1;
          end
        end else begin
          s_d.tmp  = mem_rdata_in;
          s_d.addr = s_q.pc + 16'h0001;
        end
      end
      ST_OP2: begin
        s_d.pc = s_q.pc + 16'h0001;
        if (s_q.op[5:4] == MODE_IMM) begin
          s_d.st = last ? ST_FETCH : ST_PAD;
          if (s_q.op == OP_LOAD_D_IMM) begin
            {s_d.a, s_d.b} = alu_res; // RQ10
            s_d.cc         = {alu_flags[3:2], 1'b0, s_q.cc[CC_C]};
          end else if (s_q.op == OP_CMP_X_IMM) begin
            s_d.cc = alu_flags; // RQ17
          end else begin
            {s_d.a, s_d.b} = alu_res; // RQ7 RQ15
            s_d.cc         = alu_flags;
          end
        end else begin
          s_d.ea   = {s_q.tmp, mem_rdata_in}; // RQ1
          s_d.addr = {s_q.tmp, mem_rdata_in};
          s_d.st   = ST_RD_HI;
          if (s_q.op == OP_STORE_D_EXT) begin
            s_d.wdata = s_q.a; // RQ14
            s_d.we    = 1'b1;
            s_d.st    = ST_WR1;
          end
        end
      end
      ST_RD_HI: begin
        s_d.st = ST_RD_LO;
        if (s_q.op == OP_PULL_INDEX) begin
          s_d.x[15:8] = mem_rdata_in; // RQ13
          s_d.sp      = s_q.sp + 16'h0001;
          s_d.addr    = s_q.sp + 16'h0001;
        end else begin
          s_d.tmp  = mem_rdata_in;
          s_d.addr = s_q.addr + 16'h0001;
        end
      end
      ST_RD_LO: begin
        s_d.st = last ? ST_FETCH : ST_PAD;
        if (s_q.op == OP_PULL_INDEX) begin
          s_d.x[7:0] = mem_rdata_in; // RQ13
        end else if (s_q.op == OP_CMP_X_IDX || s_q.op == OP_CMP_X_EXT) begin
          s_d.cc = alu_flags; // RQ17
        end else if (s_q.op == OP_LOAD_D_IDX || s_q.op == OP_LOAD_D_EXT) begin
          {s_d.a, s_d.b} = alu_res; // RQ10
          s_d.cc         = {alu_flags[3:2], 1'b0, s_q.cc[CC_C]};
        end else begin
          {s_d.a, s_d.b} = alu_res; // RQ7 RQ15
          s_d.cc         = alu_flags;
        end
      end
      ST_WR1: begin
        s_d.st = ST_WR2;
        s_d.we = 1'b1;
        if (s_q.op == OP_PUSH_INDEX) begin
          s_d.addr  = s_q.sp; // RQ12
          s_d.wdata = s_q.x[15:8];
          s_d.sp    = s_q.sp - 16'h0001;
        end else begin
          s_d.addr  = s_q.addr + 16'h0001; // RQ14
          s_d.wdata = s_q.b;
          s_d.cc    = {s_q.a[7], (dacc == 16'h0000), 1'b0, s_q.cc[CC_C]};
        end
      end
      ST_WR2: begin
        s_d.st = last ? ST_FETCH : ST_PAD;
      end
      ST_PAD: begin
        s_d.st = last ? ST_FETCH : ST_PAD;
      end
      default: begin
        s_d.st = ST_FETCH;
      end
    endcase
    // Byte two is read in the cycle right after the opcode
    if (s_d.st == ST_FETCH || s_d.st == ST_OP1) begin
      s_d.addr = s_d.pc;
    end
    // The cycle count restarts with every fetch
    if (s_d.st == ST_FETCH) begin
      s_d.cyc = 4'h0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_q <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_addr_out           = s_q.addr;
  assign mem_wdata_out          = s_q.wdata;
  assign mem_we_out             = s_q.we;
  assign fetch_out              = (s_q.st == ST_FETCH);
  assign illegal_out            = s_q.illegal;
  assign pc_out                 = s_q.pc;
  assign sp_out                 = s_q.sp;
  assign index_out              = s_q.x;
  assign double_accumulator_out = dacc;
  assign cc_out                 = s_q.cc;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  logic fop;
  assign fop = fetch_out;

  property p_push_index;
    fop && mem_rdata_in == OP_PUSH_INDEX |=> !fop [*3] ##1
      (fop && s_q.sp == $past(s_q.sp, 4) - 16'h0002);
  endproperty
  a_push_index: assert property (p_push_index) else $error("push index timing or SP"); // RQ12

  property p_push_order;
    fop && mem_rdata_in == OP_PUSH_INDEX |=> mem_we_out &&
      mem_wdata_out == $past(s_q.x[7:0]) ##1 mem_we_out && mem_wdata_out == $past(s_q.x[15:8], 2);
  endproperty
  a_push_order: assert property (p_push_order) else $error("push index byte order"); // RQ12

  property p_pull_index;
    fop && mem_rdata_in == OP_PULL_INDEX |-> ##5
      (fop && s_q.sp == $past(s_q.sp, 5) + 16'h0002);
  endproperty
  a_pull_index: assert property (p_pull_index) else $error("pull index timing or SP"); // RQ13

  property p_branch_never;
    fop && mem_rdata_in == OP_BRANCH_NEVER |-> ##3
      (fop && s_q.pc == $past(s_q.pc, 3) + 16'h0002);
  endproperty
  a_branch_never: assert property (p_branch_never) else $error("branch never misbehaves"); // RQ16

  property p_add_b_idx;
    fop && mem_rdata_in == OP_ADD_B_IDX |-> ##3
      (s_q.x == $past(s_q.x, 3) + {8'h00, $past(s_q.b, 3)} && s_q.cc == $past(s_q.cc, 3));
  endproperty
  a_add_b_idx: assert property (p_add_b_idx) else $error("add B to index wrong"); // RQ6

  property p_multiply;
    fop && mem_rdata_in == OP_MULTIPLY |-> ##10
      (fop && dacc == {8'h00, $past(s_q.a, 10)} * {8'h00, $past(s_q.b, 10)});
  endproperty
  a_multiply: assert property (p_multiply) else $error("multiply product wrong"); // RQ11

  property p_shift_left;
    fop && mem_rdata_in == OP_SHL_DOUBLE |-> ##3
      (dacc == {$past(dacc[14:0], 3), 1'b0} && s_q.cc[CC_C] == $past(dacc[15], 3));
  endproperty
  a_shift_left: assert property (p_shift_left) else $error("double left shift wrong"); // RQ8

  property p_shift_right;
    fop && mem_rdata_in == OP_SHR_DOUBLE |-> ##3
      (dacc == {1'b0, $past(dacc[15:1], 3)} && s_q.cc[CC_C] == $past(dacc[0], 3));
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("double right shift wrong"); // RQ9

  property p_idx_to_sp;
    fop && mem_rdata_in == OP_IDX_TO_SP |-> ##3
      (s_q.sp == $past(s_q.x, 3) - 16'h0001 && s_q.cc == $past(s_q.cc, 3));
  endproperty
  a_idx_to_sp: assert property (p_idx_to_sp) else $error("index to SP wrong"); // RQ19

  property p_idx_kept;
    fop && mem_rdata_in == OP_LOAD_D_IDX |-> ##5 (fop && s_q.x == $past(s_q.x, 5));
  endproperty
  a_idx_kept: assert property (p_idx_kept) else $error("indexed load changed index"); // RQ3

  property p_store_kept;
    fop && mem_rdata_in == OP_STORE_D_EXT |-> ##5 (fop && dacc == $past(dacc, 5));
  endproperty
  a_store_kept: assert property (p_store_kept) else $error("store changed accumulators"); // RQ14

  c_push: cover property (fop && mem_rdata_in == OP_PUSH_INDEX);
  c_pull: cover property (fop && mem_rdata_in == OP_PULL_INDEX);
  c_mul:  cover property (fop && mem_rdata_in == OP_MULTIPLY);
  c_addx: cover property (fop && mem_rdata_in == OP_ADD_D_IDX);

endmodule

// file: hdl/cad_pkg.sv
/*
  Shared constants for the addressing and double-operation core: opcodes,
  cycle counts, condition-code layout, reset values, ALU and state encodings.
  Assumes one clock domain and a byte-wide memory bus.
*/
package cad_pkg;

  localparam int unsigned CAD_ADDR_W = 16;
  localparam int unsigned CAD_DATA_W = 8;

  // Opcodes handled by the core
  localparam logic [7:0] OP_NOP         = 8'h01;
  localparam logic [7:0] OP_SHR_DOUBLE  = 8'h04;
  localparam logic [7:0] OP_SHL_DOUBLE  = 8'h05;
  localparam logic [7:0] OP_BRA         = 8'h20;
  localparam logic [7:0] OP_BRANCH_NEVER = 8'h21;
  localparam logic [7:0] OP_SP_TO_IDX   = 8'h30;
  localparam logic [7:0] OP_IDX_TO_SP   = 8'h35;
  localparam logic [7:0] OP_PULL_INDEX  = 8'h38;
  localparam logic [7:0] OP_ADD_B_IDX   = 8'h3A;
  localparam logic [7:0] OP_PUSH_INDEX  = 8'h3C;
  localparam logic [7:0] OP_MULTIPLY    = 8'h3D;
  localparam logic [7:0] OP_SUB_D_IMM   = 8'h83;
  localparam logic [7:0] OP_CMP_X_IMM   = 8'h8C;
  localparam logic [7:0] OP_SUB_D_IDX   = 8'hA3;
  localparam logic [7:0] OP_CMP_X_IDX   = 8'hAC;
  localparam logic [7:0] OP_SUB_D_EXT   = 8'hB3;
  localparam logic [7:0] OP_CMP_X_EXT   = 8'hBC;
  localparam logic [7:0] OP_ADD_D_IMM   = 8'hC3;
  localparam logic [7:0] OP_LOAD_D_IMM  = 8'hCC;
  localparam logic [7:0] OP_ADD_D_IDX   = 8'hE3;
  localparam logic [7:0] OP_LOAD_D_IDX  = 8'hEC;
  localparam logic [7:0] OP_STORE_D_IDX = 8'hED;
  localparam logic [7:0] OP_ADD_D_EXT   = 8'hF3;
  localparam logic [7:0] OP_LOAD_D_EXT  = 8'hFC;
  localparam logic [7:0] OP_STORE_D_EXT = 8'hFD;
  localparam logic [3:0] OP_BRANCH_HI   = 4'h2;

  // Addressing mode field, opcode bits 5:4 of the 16-bit operations
  localparam logic [1:0] MODE_IMM = 2'h0;
  localparam logic [1:0] MODE_IDX = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;

  // Bus cycles per instruction
  localparam logic [3:0] CYC_NOP       = 4'h2;
  localparam logic [3:0] CYC_SHORT     = 4'h3;
  localparam logic [3:0] CYC_PUSH_X    = 4'h4;
  localparam logic [3:0] CYC_PULL_X    = 4'h5;
  localparam logic [3:0] CYC_MUL       = 4'hA;
  localparam logic [3:0] CYC_ARITH_IMM = 4'h4;
  localparam logic [3:0] CYC_ARITH_MEM = 4'h6;
  localparam logic [3:0] CYC_LOAD_IMM  = 4'h3;
  localparam logic [3:0] CYC_LOAD_MEM  = 4'h5;
  localparam logic [3:0] CYC_STORE_MEM = 4'h5;

  // Condition-code bit positions
  localparam int unsigned CC_N = 3;
  localparam int unsigned CC_Z = 2;
  localparam int unsigned CC_V = 1;
  localparam int unsigned CC_C = 0;

  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00FF;
  localparam logic [3:0]  RST_CC = 4'h0;

  typedef enum logic [2:0] {
    ALU_ADD  = 3'h0,
    ALU_SUB  = 3'h1,
    ALU_SHL  = 3'h2,
    ALU_SHR  = 3'h3,
    ALU_PASS = 3'h4
  } cad_alu_op_t;

  typedef enum logic [2:0] {
    ST_FETCH = 3'b000,
    ST_OP1   = 3'b001,
    ST_OP2   = 3'b011,
    ST_RD_HI = 3'b010,
    ST_RD_LO = 3'b110,
    ST_WR1   = 3'b111,
    ST_WR2   = 3'b101,
    ST_PAD   = 3'b100
  } cad_state_t;

endpackage

// file: sim/cad_mem.sv
/*
  Byte-wide program and data memory for the core bench.
  Assumes reads are answered in the same cycle and writes land at the clock edge.
*/
`timescale 1ns/10ps
module cad_mem (
  input  wire logic        mclk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] m [0:65535];
  // Unwritten locations read as unknown so stray fetches show up at once
  assign rdata_out = m[addr_in];
  always @(posedge mclk_in) begin
    if (we_in) begin
      m[addr_in] <= wdata_in;
    end
  end
endmodule

// file: sim/tb.sv
/*
  Self-checking bench for the core: places instructions in memory one at a time.
  Assumes the core fetches back to back from address 0000 after reset.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb
  import cad_pkg::*;
;
  logic        mclk_in = 1'b0;
  logic        rst_n_in;
  logic [7:0]  rdata;
  logic [15:0] addr, pc_out, sp_out, index_out, dacc;
  logic [7:0]  wdata;
  logic        we, fetch_out, illegal;
  logic [3:0]  ccx;
  logic [3:0]  cc_out;
  logic [15:0] wp, r1, r2, r3, r4, d, x, sp;
  logic [7:0]  off;
  int          error_cnt = 0;
  int          checked = 0;
  int          seed = 83;

  always #5 mclk_in = ~mclk_in;

  cad_mem i_mem (.mclk_in(mclk_in), .addr_in(addr), .wdata_in(wdata), .we_in(we),
                 .rdata_out(rdata));
  cad_core i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .mem_rdata_in(rdata),
                  .mem_addr_out(addr), .mem_wdata_out(wdata), .mem_we_out(we),
                  .fetch_out(fetch_out), .illegal_out(illegal), .pc_out(pc_out),
                  .sp_out(sp_out), .index_out(index_out),
                  .double_accumulator_out(dacc), .cc_out(cc_out));

  function automatic logic [3:0] cmp_cc(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] r;
    r = {1'h0, a} - {1'h0, b};
    return {r[15], r[15:0] == 16'h0000, (a[15] ^ b[15]) & (r[15] ^ a[15]), r[16]};
  endfunction

  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Entered in a fetch cycle at pc wp; returns in the next fetch cycle
  task automatic ins(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
                     input int len, input int cyc, input logic [7:0] skip);
    int n;
    n = 0;
    i_mem.m[wp] = b0;
    i_mem.m[wp + 16'h0001] = b1;
    i_mem.m[wp + 16'h0002] = b2;
    do begin
      @(posedge mclk_in);
      #1;
      n++;
    end while (fetch_out !== 1'b1 && n < 20);
    `CHK(n, cyc)
    wp = wp + 16'(len) + {{8{skip[7]}}, skip};
    `CHK(pc_out, wp)
  endtask

  initial begin
    #50000;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    rst_n_in = 1'b0;
    wp = 16'h0000;
    sp = RST_SP;
    repeat (4) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    for (int it = 0; it < 3; it++) begin
      r1 = 16'($random(seed));
      r2 = 16'($random(seed));
      r3 = 16'($random(seed));
      r4 = 16'($random(seed));
      off = 8'($random(seed)) & 8'h0F;
      if (it == 0) r1 = 16'h8000;
      if (it == 1) r1 = 16'h0000;
      ins(OP_LOAD_D_IMM, r1[15:8], r1[7:0], 3, CYC_LOAD_IMM, 8'h00);
      `CHK(dacc, r1)
      `CHK(cc_out[3:1], {r1[15], r1 == 16'h0000, 1'h0})
      ins(OP_MULTIPLY, 8'h00, 8'h00, 1, CYC_MUL, 8'h00);
      d = {8'h00, r1[15:8]} * {8'h00, r1[7:0]};
      `CHK(dacc, d)
      ins(OP_SHL_DOUBLE, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      `CHK(dacc, {d[14:0], 1'h0})
      `CHK(cc_out[CC_C], d[15])
      d = {d[14:0], 1'h0};
      ins(OP_SHR_DOUBLE, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      `CHK(dacc, {1'h0, d[15:1]})
      `CHK(cc_out[CC_C], d[0])
      ins(OP_LOAD_D_IMM, r2[15:8], r2[7:0], 3, CYC_LOAD_IMM, 8'h00);
      ins(OP_STORE_D_EXT, 8'h01, 8'h00, 3, CYC_STORE_MEM, 8'h00);
      `CHK({i_mem.m[16'h0100], i_mem.m[16'h0101]}, r2)
      `CHK(dacc, r2)
      ins(OP_ADD_D_IMM, r3[15:8], r3[7:0], 3, CYC_ARITH_IMM, 8'h00);
      d = r2 + r3;
      `CHK(dacc, d)
      ins(OP_SUB_D_EXT, 8'h01, 8'h00, 3, CYC_ARITH_MEM, 8'h00);
      `CHK(dacc, r3)
      ins(OP_LOAD_D_IMM, r2[15:8], r2[7:0], 3, CYC_LOAD_IMM, 8'h00);
      ins(OP_SP_TO_IDX, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      x = sp + 16'h0001;
      `CHK(index_out, x)
      ins(OP_ADD_B_IDX, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      x = x + {8'h00, r2[7:0]};
      `CHK(index_out, x)
      `CHK(cc_out[3:1], {r2[15], r2 == 16'h0000, 1'h0})
      ins(OP_STORE_D_IDX, 8'h05, 8'h00, 2, CYC_STORE_MEM, 8'h00);
      `CHK({i_mem.m[x + 16'h0005], i_mem.m[x + 16'h0006]}, r2)
      `CHK(index_out, x)
      ins(OP_LOAD_D_IDX, 8'h05, 8'h00, 2, CYC_LOAD_MEM, 8'h00);
      `CHK(dacc, r2)
      ins(OP_ADD_D_IDX, 8'h05, 8'h00, 2, CYC_ARITH_MEM, 8'h00);
      `CHK(dacc, r2 + r2)
      ins(OP_PUSH_INDEX, 8'h00, 8'h00, 1, CYC_PUSH_X, 8'h00);
      `CHK({i_mem.m[sp], i_mem.m[sp - 16'h0001]}, {x[7:0], x[15:8]})
      sp = sp - 16'h0002;
      `CHK(sp_out, sp)
      // Clobber the index so that the pull has to restore it
      ins(OP_SP_TO_IDX, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      ins(OP_PULL_INDEX, 8'h00, 8'h00, 1, CYC_PULL_X, 8'h00);
      sp = sp + 16'h0002;
      `CHK(sp_out, sp)
      `CHK(index_out, x)
      ins(OP_IDX_TO_SP, 8'h00, 8'h00, 1, CYC_SHORT, 8'h00);
      sp = x - 16'h0001;
      `CHK(sp_out, sp)
      if (it == 0) r4 = x;
      ins(OP_CMP_X_IMM, r4[15:8], r4[7:0], 3, CYC_ARITH_IMM, 8'h00);
      `CHK(cc_out, cmp_cc(x, r4))
      ccx = cmp_cc(x, r4);
      ins(8'h27, off, 8'h00, 2, CYC_SHORT, ccx[CC_Z] ? off : 8'h00);
      ins(OP_BRANCH_NEVER, off, 8'h00, 2, CYC_SHORT, 8'h00);
      ins(OP_BRA, off, 8'h00, 2, CYC_SHORT, off);
      ins(8'h00, 8'h00, 8'h00, 1, CYC_NOP, 8'h00);
      `CHK(illegal, 1'b1)
      ins(OP_NOP, 8'h00, 8'h00, 1, CYC_NOP, 8'h00);
      `CHK(illegal, 1'b0)
    end
    report_and_stop;
  end
endmodule
